// >>> logic/panel_port_regs.svh
`ifndef PANEL_PORT_REGS_SVH
`define PANEL_PORT_REGS_SVH
// AXI4-Lite byte offsets
`define OFF_CMD        8'h00
`define OFF_WDATA      8'h04
`define OFF_RDATA      8'h08
`define OFF_CONTROL    8'h0C
`define OFF_DISPLAY    8'h10
`define OFF_STATUS     8'h14
`define OFF_MDDATA     8'h18
`define OFF_POWER      8'h1C
// Adapter address and field positions
`define ADAPTER_ADDR   8'h09
`define CMD_ADDR_LSB   8
`define CMD_MD_BIT     7
`define CMD_WRITE_BIT  3
`define ST_MD_EN       4
`define ST_DATA_ENTRY  8
`define ST_FUNC_ENTRY  9
`define ST_IRQ         15
`define CTL_BLANK      4
// Reset values
`define CONTROL_RST    16'h0000
`define STATUS_RST     16'h0000
// Power-on sequence, about 70 s
`define PWR_SEQ_SEC    70
`define CLK_HZ         25000000
`define PWR_SEQ_CYC    (`PWR_SEQ_SEC * `CLK_HZ)
`endif

// >>> logic/panel_port_pkg.sv
package panel_port_pkg;
    // Register selected by a decoded command
    typedef enum logic [1:0] {
        SEL_CONTROL,
        SEL_DISPLAY,
        SEL_STATUS,
        SEL_MDDATA
    } reg_sel_type;
    // Power sequencing states
    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_SEQ,
        PWR_ON
    } pwr_state_type;
endpackage

// >>> logic/pio_cmd_if.sv
`timescale 1ns/1ps
// Carries one decoded halfword command to the register file
interface pio_cmd_if;
    logic        valid;
    logic        write;
    logic        toMd;
    logic [1:0]  sel;
    logic [15:0] data;
    modport source (output valid, output write, output toMd, output sel, output data);
    modport sink   (input valid, input write, input toMd, input sel, input data);
endinterface

// >>> logic/pio_cmd_decoder.sv
`timescale 1ns/1ps
`include "panel_port_regs.svh"
module pio_cmd_decoder
    import panel_port_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Command from the direct control bus relay
    input  wire logic        go,
    input  wire logic [15:0] cmd,
    input  wire logic [15:0] wdata,
    input  wire logic        mdEnabled,
    // Decoded command
    pio_cmd_if.source        out
);
    // ------------------------------------------------------------
    // Address match and operation decode
    // ------------------------------------------------------------
    logic match;
    logic isMd;
    assign match = (cmd[15:`CMD_ADDR_LSB] == `ADAPTER_ADDR);
    assign isMd  = cmd[`CMD_MD_BIT];

    // One registered command per go; md commands need enable
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out.valid <= 1'b0;
            out.write <= 1'b0;
            out.toMd  <= 1'b0;
            out.sel   <= 2'h0;
            out.data  <= 16'h0000;
        end else begin
            out.valid <= go && match && (!isMd || mdEnabled);
            out.write <= cmd[`CMD_WRITE_BIT];
            out.toMd  <= isMd;
            out.sel   <= cmd[1:0];
            out.data  <= wdata;
        end
    end
endmodule

// >>> logic/operator_panel_adapter_port.sv
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "panel_port_regs.svh"
// What this block does
// - Answer only commands addressed to fixed adapter address 09 hex.
// - Act as a halfword adapter, one halfword per transfer.
// - Recognise own address during program load and ordinary transfers.
// - Pass maintenance device commands only when status bit 4 set.
// - Decode operation and target, panel or maintenance device.
// - 16-bit transfers read and modify control, display, status, device registers.
// - Power-on starts roughly 70 s sequence; indicators invalid meanwhile.
// - After sequence, indicators take reset state and program load starts.
// - Power-on indicator lit from sequence start, follows 5V sense.
// - Power-on-disabled latch set by power-off command or post-check restore.
// - With keylock, latch also set if power removed while secure.
// - Latch clears only with keylock enable/power-only and switch off.
// - Power/thermal check set by voltage, brake, overtemperature or interlock.
// - Power/thermal check clears only by switch off then on.
// - Power-on also sequences expansion units whose switches are on.
// - Enter-data button sets status bits 8 and 15.
// - Enter-function button sets status bits 9 and 15.
// - Control bit 4 blocks display transfers and blanks display.
// - Clear-display zeroes display only, no interrupt request.
module operator_panel_adapter_port
    import panel_port_pkg::*;
#(
    parameter int unsigned PWR_SEQ_CYCLES = `PWR_SEQ_CYC
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Panel pushbuttons, one-cycle pulses
    input  wire logic        enterDataPress,
    input  wire logic        enterFuncPress,
    input  wire logic        clearDisplayPress,
    input  wire logic [15:0] keypadValue,
    // Power and keylock inputs
    input  wire logic        powerSwitchOn,
    input  wire logic        supply5vSense,
    input  wire logic        keylockFitted,
    input  wire logic        keylockSecure,
    input  wire logic        utilityPowerGood,
    input  wire logic        voltageFault,
    input  wire logic        diskBrakeApplied,
    input  wire logic        cpuOverTemp,
    input  wire logic        diskInterlockOpen,
    input  wire logic [3:0]  expansionSwitchOn,
    // Panel and system outputs
    output logic [15:0]      displayOut,
    output logic             displayBlank,
    output logic             powerOnLamp,
    output logic             powerOnDisabledLamp,
    output logic             powerCheckLamp,
    output logic             indicatorsValid,
    output logic             systemPowerEnable,
    output logic [3:0]       expansionSeqStart,
    output logic             loadStart,
    output logic             mdStrobe,
    output logic [15:0]      mdDataOut
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [15:0]   cmd_q;
    logic [15:0]   wdata_q;
    logic [15:0]   rdata_q;
    logic [15:0]   control_q;
    logic [15:0]   display_q;
    logic [15:0]   status_q;
    logic [15:0]   mdData_q;
    logic          pwrOffCmd;
    logic          pioGo;
    pwr_state_type pwr_q;
    logic [31:0]   seqCount_q;
    logic          lostWhileSecure_q;
    logic          hadCheck_q;
    logic          utilPrev_q;
    logic          switchPrev_q;
    logic          checkLatch_q;
    logic          disabledLatch_q;
    logic          awHeld_q;
    logic          wHeld_q;
    logic [7:0]    awAddr_q;
    logic [31:0]   wData_q;
    logic [3:0]    wStrb_q;
    logic          wrFire;
    logic          awOk;
    pio_cmd_if     cmdBus ();

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    pio_cmd_decoder u_dec (
        .clk       (clk),
        .reset     (reset),
        .go        (pioGo),
        .cmd       (cmd_q),
        .wdata     (wdata_q),
        .mdEnabled (status_q[`ST_MD_EN]),
        .out       (cmdBus)
    );

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    assign wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign awOk   = (awAddr_q[1:0] == 2'h0) && (awAddr_q <= `OFF_POWER);

    // Capture address and data in either order
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            awAddr_q      <= 8'h00;
            wData_q       <= 32'h0000_0000;
            wStrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q      <= 1'b1;
                awAddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q      <= 1'b1;
                wData_q      <= s_axi_wdata;
                wStrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrFire) begin
                awHeld_q <= 1'b0;
                wHeld_q  <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Write response; unmapped gives SLVERR
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= awOk ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Command and data staging; writing the command starts a transfer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_q   <= 16'h0000;
            wdata_q <= 16'h0000;
            pioGo   <= 1'b0;
        end else begin
            pioGo <= wrFire && (awAddr_q == `OFF_CMD) && (&wStrb_q[1:0]);
            if (wrFire && awAddr_q == `OFF_CMD && (&wStrb_q[1:0])) begin
                cmd_q <= wData_q[15:0];
            end
            if (wrFire && awAddr_q == `OFF_WDATA && (&wStrb_q[1:0])) begin
                wdata_q <= wData_q[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Panel registers
    // ------------------------------------------------------------
    // Control and maintenance data updated only by accepted commands
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            control_q <= `CONTROL_RST;
            mdData_q  <= 16'h0000;
            mdStrobe  <= 1'b0;
            mdDataOut <= 16'h0000;
        end else begin
            mdStrobe <= cmdBus.valid && cmdBus.toMd;
            if (cmdBus.valid && cmdBus.toMd && cmdBus.write) begin
                mdData_q  <= cmdBus.data;
                mdDataOut <= cmdBus.data;
            end
            if (cmdBus.valid && !cmdBus.toMd && cmdBus.write && cmdBus.sel == SEL_CONTROL) begin
                control_q <= cmdBus.data;
            end
        end
    end

    // Display: clear button only touches this register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            display_q <= 16'h0000;
        end else if (clearDisplayPress) begin
            display_q <= 16'h0000;
        end else if (cmdBus.valid && !cmdBus.toMd && cmdBus.write && cmdBus.sel == SEL_DISPLAY
                     && !control_q[`CTL_BLANK]) begin
            display_q <= cmdBus.data;
        end else if (enterDataPress || enterFuncPress) begin
            display_q <= keypadValue;
        end
    end

    // Status: button set wins over a software write that same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_q <= `STATUS_RST;
        end else begin
            if (pwr_q == PWR_SEQ && seqCount_q == PWR_SEQ_CYCLES - 1) begin
                status_q <= `STATUS_RST;
            end else if (cmdBus.valid && !cmdBus.toMd && cmdBus.write && cmdBus.sel == SEL_STATUS) begin
                status_q <= cmdBus.data;
            end
            if (enterDataPress) begin
                status_q[`ST_DATA_ENTRY] <= 1'b1;
                status_q[`ST_IRQ]        <= 1'b1;
            end
            if (enterFuncPress) begin
                status_q[`ST_FUNC_ENTRY] <= 1'b1;
                status_q[`ST_IRQ]        <= 1'b1;
            end
        end
    end

    // Read-back of a command; display reads zero while blanked
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 16'h0000;
        end else if (cmdBus.valid && !cmdBus.write) begin
            if (cmdBus.toMd) begin
                rdata_q <= mdData_q;
            end else begin
                case (reg_sel_type'(cmdBus.sel))
                    SEL_CONTROL: rdata_q <= control_q;
                    SEL_DISPLAY: rdata_q <= control_q[`CTL_BLANK] ? 16'h0000 : display_q;
                    SEL_STATUS:  rdata_q <= status_q;
                    default:     rdata_q <= mdData_q;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Power sequencing
    // ------------------------------------------------------------
    assign pwrOffCmd = wrFire && awAddr_q == `OFF_POWER && wStrb_q[0] && wData_q[0];

    // Sequence timer; a disabled latch forbids starting
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pwr_q      <= PWR_OFF;
            seqCount_q <= 32'h0000_0000;
            loadStart  <= 1'b0;
        end else begin
            loadStart <= 1'b0;
            case (pwr_q)
                PWR_OFF: begin
                    seqCount_q <= 32'h0000_0000;
                    if (powerSwitchOn && !switchPrev_q && !disabledLatch_q
                        && !(keylockFitted && keylockSecure)) begin
                        pwr_q <= PWR_SEQ;
                    end
                end
                PWR_SEQ: begin
                    seqCount_q <= seqCount_q + 32'h0000_0001;
                    if (seqCount_q == PWR_SEQ_CYCLES - 1) begin
                        pwr_q     <= PWR_ON;
                        loadStart <= 1'b1;
                    end
                end
                PWR_ON: begin
                    seqCount_q <= 32'h0000_0000;
                end
                default: pwr_q <= PWR_OFF;
            endcase
            if (!powerSwitchOn || pwrOffCmd || !utilityPowerGood || voltageFault || diskBrakeApplied
                || cpuOverTemp || diskInterlockOpen) begin
                pwr_q <= PWR_OFF;
            end
        end
    end

    // Power check and disabled latches
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            checkLatch_q      <= 1'b0;
            disabledLatch_q   <= 1'b0;
            lostWhileSecure_q <= 1'b0;
            hadCheck_q        <= 1'b0;
            utilPrev_q        <= 1'b1;
            switchPrev_q      <= 1'b0;
        end else begin
            utilPrev_q   <= utilityPowerGood;
            switchPrev_q <= powerSwitchOn;
            if (!utilityPowerGood) begin
                lostWhileSecure_q <= keylockFitted && keylockSecure;
                hadCheck_q        <= checkLatch_q;
            end
            if (powerSwitchOn && !switchPrev_q) begin
                checkLatch_q <= 1'b0;
            end
            if (pwr_q != PWR_OFF && (voltageFault || diskBrakeApplied || cpuOverTemp || diskInterlockOpen)) begin
                checkLatch_q <= 1'b1;
            end
            if (!powerSwitchOn && !(keylockFitted && keylockSecure)) begin
                disabledLatch_q <= 1'b0;
            end
            if (pwrOffCmd || (utilityPowerGood && !utilPrev_q && (hadCheck_q || lostWhileSecure_q))) begin
                disabledLatch_q <= 1'b1;
            end
        end
    end

    // Lamps and enables, all registered
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            powerOnLamp         <= 1'b0;
            powerOnDisabledLamp <= 1'b0;
            powerCheckLamp      <= 1'b0;
            indicatorsValid     <= 1'b0;
            systemPowerEnable   <= 1'b0;
            expansionSeqStart   <= 4'h0;
            displayOut          <= 16'h0000;
            displayBlank        <= 1'b1;
        end else begin
            powerOnLamp         <= supply5vSense && pwr_q != PWR_OFF;
            powerOnDisabledLamp <= disabledLatch_q;
            powerCheckLamp      <= checkLatch_q;
            indicatorsValid     <= pwr_q == PWR_ON;
            systemPowerEnable   <= pwr_q != PWR_OFF;
            expansionSeqStart   <= (pwr_q == PWR_SEQ && seqCount_q == 32'h0000_0000)
                                   ? expansionSwitchOn : 4'h0;
            displayOut          <= control_q[`CTL_BLANK] ? 16'h0000 : display_q;
            displayBlank        <= control_q[`CTL_BLANK];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel, answer one cycle after address
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            case (s_axi_araddr)
                `OFF_CMD:     s_axi_rdata <= {16'h0000, cmd_q};
                `OFF_WDATA:   s_axi_rdata <= {16'h0000, wdata_q};
                `OFF_RDATA:   s_axi_rdata <= {16'h0000, rdata_q};
                `OFF_CONTROL: s_axi_rdata <= {16'h0000, control_q};
                `OFF_DISPLAY: s_axi_rdata <= {16'h0000, display_q};
                `OFF_STATUS:  s_axi_rdata <= {16'h0000, status_q};
                `OFF_MDDATA:  s_axi_rdata <= {16'h0000, mdData_q};
                `OFF_POWER:   s_axi_rdata <= {26'h0, pwr_q == PWR_ON, indicatorsValid, powerCheckLamp,
                                              powerOnDisabledLamp, powerOnLamp, 1'b0};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// >>> tb/panel_port_monitor.sv
`timescale 1ns/1ps
// Checks on the adapter's pins
module panel_port_monitor (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // Bus and panel outputs
    input wire logic        s_axi_awready, s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready,
    input wire logic        displayBlank, loadStart, mdStrobe,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [3:0]  expansionSwitchOn, expansionSeqStart,
    input wire logic [15:0] displayOut,
    input wire logic [31:0] s_axi_rdata
);
    // One clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata moved");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == '0) else $error("upper half set");
    a_refused_empty: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == '0)
        else $error("refused data");
    a_blank_dark: assert property (displayBlank |-> displayOut == '0) else $error("blank display lit");
    a_load_once: assert property (loadStart |=> !loadStart [*8]) else $error("load repeated");
    a_exp_gated: assert property (|expansionSeqStart |-> (expansionSeqStart & ~expansionSwitchOn) == 4'h0)
        else $error("unit switch off");
    a_md_pulse: assert property (mdStrobe |=> !mdStrobe) else $error("strobe too long");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("awready in answer");
endmodule
bind operator_panel_adapter_port panel_port_monitor mon (.*);

// >>> tb/scf_relay_model.sv
`timescale 1ns/1ps
// Relay of processor halfword I/O onto the bus
module scf_relay_model (
    // Clock and slave answers
    input  wire logic        clk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
    input  wire logic [1:0]  s_axi_bresp, s_axi_rresp,
    input  wire logic [31:0] s_axi_rdata,
    // Master requests
    output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
    output logic [7:0]       s_axi_awaddr, s_axi_araddr,
    output logic [3:0]       s_axi_wstrb,
    output logic [31:0]      s_axi_wdata
);
    int slow = 0;
    // Idle bus from time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 52'h0_000F_0000_0000;
    end
    // One transfer; released lines show the inverse
    task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d, output logic [47:0] v, output bit ok);
        int n = 0;
        ok = 1'b0;
        @(posedge clk);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
        end
        while (!ok && n < 200) begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
            if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
            if (s_axi_bready && s_axi_bvalid || s_axi_rready && s_axi_rvalid) begin
                v = w ? {14'h0, s_axi_bresp, 32'h0} : {14'h0, s_axi_rresp, s_axi_rdata};
                {s_axi_bready, s_axi_rready} <= 2'h0;
                ok = 1'b1;
            end else if (n > slow) {s_axi_bready, s_axi_rready} <= {w, !w};
        end
    endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "panel_port_regs.svh"
// Bench with 16-bit array register model
module tb_top;
    localparam int SEQ = 20;
    logic        clk, reset, enterDataPress, enterFuncPress, clearDisplayPress, powerSwitchOn, supply5vSense;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, displayBlank, powerOnLamp;
    logic        powerOnDisabledLamp, powerCheckLamp, indicatorsValid, systemPowerEnable, loadStart, mdStrobe;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb, expansionSwitchOn, expansionSeqStart, flt;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [15:0] keypadValue, displayOut, mdDataOut, d, mr [3];
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [47:0] v;
    int          n_errors = 0, cmp_count = 0, nLoad = 0, nMd = 0, nExp = 0;
    operator_panel_adapter_port #(.PWR_SEQ_CYCLES(SEQ)) dut (.*, .keylockFitted(1'b0), .keylockSecure(1'b0),
        .utilityPowerGood(1'b1), .voltageFault(flt[0]), .diskBrakeApplied(flt[1]), .cpuOverTemp(flt[2]),
        .diskInterlockOpen(flt[3]));
    scf_relay_model m (.*);
    // Free-running 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Count one-cycle pulses
    always @(posedge clk) begin
        if (reset === 1'b0) begin
            nLoad += int'(loadStart === 1'b1);
            nMd += int'(mdStrobe === 1'b1);
            nExp += $countones(expansionSeqStart);
        end
    end
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic finish_test();
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Hung slave ends the run
    task automatic io(input bit w, input logic [7:0] a, input logic [31:0] wd);
        bit ok;
        m.xfer(w, a, wd, v, ok);
        if (!ok) begin
            n_errors++;
            finish_test();
        end
    endtask
    // Halfword command, then decode latency
    task automatic pio(input logic [15:0] c, input logic [15:0] wd);
        io(1, `OFF_WDATA, {16'h0, wd});
        io(1, `OFF_CMD, {16'h0, c});
        repeat (4) @(posedge clk);
    endtask
    task automatic pulse(input logic [2:0] p);
        {clearDisplayPress, enterFuncPress, enterDataPress} <= p;
        @(posedge clk);
        {clearDisplayPress, enterFuncPress, enterDataPress} <= 3'h0;
        repeat (4) @(posedge clk);
    endtask
    // Main sequence
    initial begin
        reset = 1'b1;
        {enterDataPress, enterFuncPress, clearDisplayPress, powerSwitchOn, supply5vSense, flt} = 9'h000;
        keypadValue = 16'h0000;
        expansionSwitchOn = 4'h5;
        mr = '{default: 16'h0000};
        void'($urandom(50));
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        io(0, 8'h20, 0);
        chk(v, 48'h2_0000_0000);
        io(1, 8'h20, 1);
        chk(v, 48'h2_0000_0000);
        // Own and foreign addresses, varied answer delay
        for (int i = 0; i < 6; i++) begin
            m.slow = i;
            d = 16'($urandom) & 16'hFFEF;
            pio({(i % 2) ? 8'h09 : 8'h09 ^ 8'(1 << i), 8'h08}, d);
            if (i % 2) mr[0] = d;
            io(0, `OFF_CONTROL, 0);
            chk(v, mr[0]);
        end
        d = 16'($urandom);
        pio(16'h0909, d);
        mr[1] = d;
        // Buttons latch keypad, set entry bits
        for (int b = 0; b < 2; b++) begin
            keypadValue <= 16'($urandom);
            @(posedge clk);
            pulse(3'(1 << b));
            mr[1] = keypadValue;
            mr[2] = mr[2] | 16'h8000 | 16'(16'h0100 << b);
            chk(displayOut, mr[1]);
            io(0, `OFF_STATUS, 0);
            chk(v, mr[2]);
        end
        for (int s = 0; s < 3; s++) begin
            pio(16'h0900 | 16'(s), 16'h0000);
            io(0, `OFF_RDATA, 0);
            chk(v, mr[s]);
        end
        pulse(3'h4);
        chk(displayOut, 16'h0000);
        io(0, `OFF_STATUS, 0);
        chk(v, mr[2]);
        // Blanking hides and locks display
        pio(16'h0908, 16'h0010);
        chk({displayBlank, displayOut}, 17'h10000);
        pio(16'h0909, 16'h1234);
        pio(16'h0908, 16'h0000);
        chk({displayBlank, displayOut}, 17'h00000);
        // Device commands need status bit 4
        d = 16'($urandom);
        pio(16'h098B, d);
        chk(nMd, 0);
        pio(16'h090A, 16'h0010);
        pio(16'h098B, d);
        chk({nMd, mdDataOut}, {32'd1, d});
        // Power-on sequence, then programmed power-off
        {supply5vSense, powerSwitchOn} <= 2'h3;
        repeat (4) @(posedge clk);
        chk(indicatorsValid, 1'b0);
        repeat (SEQ + 8) @(posedge clk);
        chk({nLoad, nExp, powerOnLamp, indicatorsValid}, {32'd1, 32'd2, 2'h3});
        io(1, `OFF_POWER, 1);
        repeat (4) @(posedge clk);
        chk(powerOnDisabledLamp, 1'b1);
        powerSwitchOn <= 1'b0;
        repeat (4) @(posedge clk);
        chk(powerOnDisabledLamp, 1'b0);
        // Each fault sets check; switch cycle clears
        for (int i = 0; i < 4; i++) begin
            powerSwitchOn <= 1'b1;
            repeat (SEQ + 8) @(posedge clk);
            flt <= 4'(1 << i);
            repeat (4) @(posedge clk);
            flt <= 4'h0;
            chk(powerCheckLamp, 1'b1);
            powerSwitchOn <= 1'b0;
            repeat (4) @(posedge clk);
            powerSwitchOn <= 1'b1;
            repeat (4) @(posedge clk);
            chk(powerCheckLamp, 1'b0);
            powerSwitchOn <= 1'b0;
            repeat (4) @(posedge clk);
        end
        finish_test();
    end
endmodule
